// [hw/upce_port_status.sv]
// Connect and enable status logic for one downstream host port.
// Assumes the line state, speed result and software strobes are synchronous
// to core_clk; the line monitor reports attachment and speed after reset.
`timescale 1ns/1ps

// Functional notes
// - Enable only from own reset sequence
// - Software write of one never enables
// - Enable after reset only if high-speed
// - Disconnect, fault or written zero disables
// - Enabled flag follows actual port state
// - Block downstream data while disabled, except reset
// - No port power forces flags to zero, except the over-current active and change flags
// - Every connect transition sets change flag
// - Change flag sticky across repeated transitions
// - Writing one clears the change flag
// - Present flag shows attachment in real time
// - Present flag shows latest state only
// - Flags read zero after reset
// - Enable-change and overcurrent-change are write-one-clear
module upce_port_status
	import upce_pkg::*;
(
	input  wire logic core_clk,                   // Core clock, 100 MHz
	input  wire logic resetn,                     // Synchronous reset, active low
	input  wire logic port_power,                 // Port power is on
	input  wire logic line_attached,              // Line monitor sees a device
	input  wire logic line_fault,                 // Port fault such as babble
	input  wire logic line_overcurrent,           // Over-current sensed
	input  wire logic reset_found_hs,             // Reset handshake found high-speed
	input  wire logic sw_port_reset,              // Software starts a port reset
	input  wire logic sw_wr,                      // Software writes the status word
	input  wire logic [UPCE_STATUS_W-1:0] sw_wdata, // Data written
	input  wire logic tx_data_valid,              // Downstream data offered
	output logic [UPCE_STATUS_W-1:0] status_q,    // Status word as read
	output logic port_enabled_flag,               // Port is enabled
	output logic connect_change_flag,             // Connect status changed
	output logic connect_present_flag,            // Device present
	output logic enable_change_flag,              // Enable dropped by a fault
	output logic overcurrent_change_flag,         // Over-current status changed
	output logic port_reset_active_q,             // Reset signalling on the line
	output logic tx_data_pass_q                   // Downstream data let through
);

	upce_state_t                 state_q;        // Port state
	upce_state_t                 state_d;        // Next port state
	logic [UPCE_CNT_W-1:0]       rst_cnt_q;      // Reset length counter
	logic                        present_q;      // Registered attachment
	logic                        present_prev_q; // Attachment one cycle ago
	logic                        oc_q;           // Registered over-current
	logic                        oc_prev_q;      // Over-current one cycle ago
	logic                        conn_event;     // Attachment transition
	logic                        oc_event;       // Over-current transition
	logic                        fault_drop;     // Hardware disable from fault
	logic                        conn_chg;       // Sticky connect change
	logic                        en_chg;         // Sticky enable change
	logic                        oc_chg;         // Sticky over-current change

	// True while the state machine holds the port enabled
	// Shared by the fault path, the flags and the traffic gate
	function automatic logic st_enabled(upce_state_t s);
		return s == UPCE_ST_ENABLED;
	endfunction

	// Sample line state; cleared while unpowered so the present flag reads zero
	// The previous sample feeds the connect transition detect
	always_ff @(posedge core_clk) begin
		if (!resetn || !port_power) begin
			present_q      <= UPCE_RST_FLAG;
			present_prev_q <= UPCE_RST_FLAG;
		end else begin
			present_q      <= line_attached;
			present_prev_q <= present_q;
		end
	end

	// Over-current status, kept even without power
	// It also feeds the fault path that drops an enabled port
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			oc_q      <= UPCE_RST_FLAG;
			oc_prev_q <= UPCE_RST_FLAG;
		end else begin
			oc_q      <= line_overcurrent;
			oc_prev_q <= oc_q;
		end
	end

	// Transition detects
	assign conn_event = present_q ^ present_prev_q;
	assign oc_event   = oc_q ^ oc_prev_q;

	// Hardware drops the enable on disconnect or fault
	// Over-current counts as a fault for as long as it lasts
	assign fault_drop = st_enabled(state_q) &&
		(!present_q || line_fault || oc_q);

	// Next port state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			UPCE_ST_DISABLED: begin
				// A written one to the enable bit is not looked at here
				if (sw_port_reset && present_q) begin
					state_d = UPCE_ST_RESETTING;
				end
			end
			UPCE_ST_RESETTING: begin
				// A device that leaves mid-reset ends the sequence disabled
				if (!present_q) begin
					state_d = UPCE_ST_DISABLED;
				end else if (rst_cnt_q == UPCE_CNT_ZERO) begin
					state_d = reset_found_hs ? UPCE_ST_ENABLED : UPCE_ST_DISABLED;
				end
			end
			UPCE_ST_ENABLED: begin
				// Hardware faults win over software requests
				if (fault_drop) begin
					state_d = UPCE_ST_DISABLED;
				end else if (sw_port_reset) begin
					state_d = UPCE_ST_RESETTING;
				end else if (sw_wr && !sw_wdata[UPCE_BIT_ENABLED]) begin
					state_d = UPCE_ST_DISABLED;
				end
			end
		endcase
	end

	// Port state register; the flag is derived from it so it only moves with it
	always_ff @(posedge core_clk) begin
		if (!resetn || !port_power) begin
			state_q <= UPCE_ST_DISABLED;
		end else begin
			state_q <= state_d;
		end
	end

	// Reset length counter, loaded on entry to reset
	// Zero marks the end of reset signalling and the speed decision
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rst_cnt_q <= UPCE_CNT_ZERO;
		end else if (state_q != UPCE_ST_RESETTING) begin
			rst_cnt_q <= UPCE_CNT_W'(UPCE_PORT_RESET_CYC - 1);
		end else if (rst_cnt_q != UPCE_CNT_ZERO) begin
			rst_cnt_q <= rst_cnt_q - 1'b1;
		end
	end

	// Sticky connect change
	upce_change_latch u_conn_chg (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.power_on  (port_power),
		.event_in  (conn_event),
		.clear_wr  (sw_wr),
		.clear_bit (sw_wdata[UPCE_BIT_CONNCHG]),
		.flag_q    (conn_chg)
	);

	// Sticky enable change, set only when hardware drops the enable
	upce_change_latch u_en_chg (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.power_on  (port_power),
		.event_in  (fault_drop),
		.clear_wr  (sw_wr),
		.clear_bit (sw_wdata[UPCE_BIT_ENCHG]),
		.flag_q    (en_chg)
	);

	// Sticky over-current change, kept through power loss
	upce_change_latch u_oc_chg (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.power_on  (1'b1),
		.event_in  (oc_event),
		.clear_wr  (sw_wr),
		.clear_bit (sw_wdata[UPCE_BIT_OVERCURRENT_CHANGE_FLAG]),
		.flag_q    (oc_chg)
	);

	// Registered outputs; the flags are one cycle behind the sources
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			port_enabled_flag       <= UPCE_RST_FLAG;
			connect_change_flag     <= UPCE_RST_FLAG;
			connect_present_flag    <= UPCE_RST_FLAG;
			enable_change_flag      <= UPCE_RST_FLAG;
			overcurrent_change_flag <= UPCE_RST_FLAG;
			status_q                <= '0;
		end else begin
			// Separate flag ports
			port_enabled_flag       <= port_power && st_enabled(state_q);
			connect_change_flag     <= port_power && conn_chg;
			connect_present_flag    <= port_power && present_q;
			enable_change_flag      <= en_chg;
			overcurrent_change_flag <= oc_chg;
			// Status word as software reads it; bit 3 is power gated in its latch, bits 4 and 5 not at all
			status_q[UPCE_BIT_PRESENT]  <= port_power && present_q;
			status_q[UPCE_BIT_CONNCHG]  <= port_power && conn_chg;
			status_q[UPCE_BIT_ENABLED]  <= port_power && st_enabled(state_q);
			status_q[UPCE_BIT_ENCHG]    <= en_chg;
			status_q[UPCE_BIT_OCACTIVE] <= oc_q;
			status_q[UPCE_BIT_OVERCURRENT_CHANGE_FLAG]    <= oc_chg;
		end
	end

	// Traffic gate: only reset signalling passes while disabled
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			port_reset_active_q <= 1'b0;
			tx_data_pass_q      <= 1'b0;
		end else begin
			// Reset signalling is the one thing driven while disabled
			port_reset_active_q <= port_power && (state_q == UPCE_ST_RESETTING);
			tx_data_pass_q      <= port_power && tx_data_valid &&
				st_enabled(state_q);
		end
	end

endmodule

// [hw/upce_pkg.sv]
// Constants and types for the port connect and enable status block.
// Assumes a single core clock of 100 MHz and a synchronous active-low reset.
package upce_pkg;

	// Bit positions inside the port status word
	localparam int unsigned UPCE_BIT_PRESENT  = 0;
	localparam int unsigned UPCE_BIT_CONNCHG  = 1;
	localparam int unsigned UPCE_BIT_ENABLED  = 2;
	localparam int unsigned UPCE_BIT_ENCHG    = 3;
	localparam int unsigned UPCE_BIT_OCACTIVE = 4;
	localparam int unsigned UPCE_BIT_OVERCURRENT_CHANGE_FLAG    = 5;
	localparam int unsigned UPCE_STATUS_W     = 6;

	// Values after reset
	localparam logic UPCE_RST_FLAG = 1'b0;

	// Port reset length and the clock it is counted on
	localparam int unsigned UPCE_CLK_MHZ        = 100;
	localparam int unsigned UPCE_PORT_RESET_US  = 10;
	localparam int unsigned UPCE_PORT_RESET_CYC = UPCE_PORT_RESET_US * UPCE_CLK_MHZ;
	localparam int unsigned UPCE_CNT_W          = 11;
	localparam logic [UPCE_CNT_W-1:0] UPCE_CNT_ZERO = 11'h000;

	// Port state machine
	typedef enum logic [1:0] {
		UPCE_ST_DISABLED,
		UPCE_ST_RESETTING,
		UPCE_ST_ENABLED
	} upce_state_t;

endpackage

// [hw/upce_change_latch.sv]
// Sticky change flag, set by hardware events and cleared by writing a one.
// Assumes the event and the clear strobe are synchronous to core_clk.
`timescale 1ns/1ps
module upce_change_latch
	import upce_pkg::*;
(
	input  wire logic core_clk,   // Core clock
	input  wire logic resetn,     // Synchronous reset, active low
	input  wire logic power_on,   // Port power; flag held at zero without it
	input  wire logic event_in,   // One-cycle change event
	input  wire logic clear_wr,   // Software write strobe
	input  wire logic clear_bit,  // Data bit written; one clears
	output logic      flag_q      // Sticky flag
);

	// Set wins over a clear in the same cycle; a written zero changes nothing
	always_ff @(posedge core_clk) begin
		if (!resetn || !power_on) begin
			flag_q <= UPCE_RST_FLAG;
		end else if (event_in) begin
			flag_q <= 1'b1;
		end else if (clear_wr && clear_bit) begin
			flag_q <= 1'b0;
		end
	end
endmodule

// [tb/upce_port_status_asserts.sv]
// Checker for the port connect and enable status block.
// Sees only the top module ports; bound from the bench top.
`timescale 1ns/1ps
module upce_port_status_asserts
	import upce_pkg::*;
(
	input wire logic                     core_clk,
	input wire logic                     resetn,
	input wire logic                     port_power,
	input wire logic                     line_attached,
	input wire logic                     line_fault,
	input wire logic                     reset_found_hs,
	input wire logic                     sw_port_reset,
	input wire logic                     sw_wr,
	input wire logic [UPCE_STATUS_W-1:0] sw_wdata,
	input wire logic                     tx_data_valid,
	input wire logic                     port_enabled_flag,
	input wire logic                     connect_change_flag,
	input wire logic                     connect_present_flag,
	input wire logic                     port_reset_active_q,
	input wire logic                     tx_data_pass_q
);
	// One domain, so clock and reset are given once
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	AST_HW_ENABLE: assert property ($rose(port_enabled_flag) |-> $past(port_reset_active_q))
		else $error("enable rose without a port reset");
	AST_HS_ONLY: assert property ($rose(port_enabled_flag) |-> $past(reset_found_hs))
		else $error("enable rose without high-speed result");
	AST_FAULT_OFF: assert property (port_enabled_flag && line_fault |-> ##[1:3] !port_enabled_flag)
		else $error("fault left the port enabled");
	AST_SW_OFF: assert property (port_enabled_flag && sw_wr && !sw_wdata[2] && !sw_port_reset
		|-> ##2 !port_enabled_flag)
		else $error("written zero left the port enabled");
	AST_TX_GATE: assert property (tx_data_pass_q |-> port_enabled_flag && $past(tx_data_valid))
		else $error("data passed while disabled");
	AST_POWER_OFF: assert property (!port_power
		|-> ##2 !(port_enabled_flag || connect_change_flag || connect_present_flag))
		else $error("flags set without port power");
	AST_CHG_SET: assert property ($changed(connect_present_flag) && port_power && $past(port_power)
		|-> ##1 connect_change_flag)
		else $error("connect transition not latched");
	AST_STICKY: assert property (connect_change_flag && port_power && $past(port_power)
		&& !(sw_wr && sw_wdata[1]) && !$past(sw_wr && sw_wdata[1]) |=> connect_change_flag)
		else $error("change flag dropped without a clear");
	AST_PRESENT: assert property (port_power && $past(port_power) && $past(port_power, 2)
		&& $past(port_power, 3) && $past(resetn) && $past(resetn, 2)
		|-> connect_present_flag == $past(line_attached, 2))
		else $error("present flag does not follow the line");

	// Main scenarios reached
	cover property ($rose(port_enabled_flag));
	cover property ($rose(connect_change_flag));
	cover property (tx_data_pass_q);
endmodule

// [tb/upce_usb_dev_model.sv]
// Model of the device on the downstream port.
// The bench plugs it and picks its speed; lines follow at the next rising edge.
`timescale 1ns/1ps
module upce_usb_dev_model (
	input  wire logic core_clk,       // Core clock
	input  wire logic plug,           // Device plugged in
	input  wire logic hs_capable,     // Device answers reset as high-speed
	output logic      line_attached,  // Attachment seen on the line
	output logic      reset_found_hs  // Speed result of the reset handshake
);
	initial line_attached = 1'b0;
	initial reset_found_hs = 1'b0;
	// Speed is only reported while something is attached
	// Non-blocking on the rising edge, so the bench's falling-edge writes never race it
	always @(posedge core_clk) begin
		line_attached <= plug;
		reset_found_hs <= plug && hs_capable;
	end
endmodule

// [tb/tb_usb_host_port_connect_enable_status.sv]
// Bench for the port connect and enable status block.
// One 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
module tb_usb_host_port_connect_enable_status;
	import upce_pkg::*;
	typedef logic [UPCE_STATUS_W-1:0] upce_word_t;
	logic core_clk, resetn, port_power, line_fault, line_overcurrent, sw_port_reset, sw_wr;
	logic tx_data_valid, plug, hs, line_attached, reset_found_hs, port_enabled_flag;
	logic connect_change_flag, connect_present_flag, enable_change_flag, overcurrent_change_flag;
	logic port_reset_active_q, tx_data_pass_q;
	upce_word_t sw_wdata, status_q;
	int failures, comparisons, cycles;

	upce_usb_dev_model u_dev (.core_clk, .plug, .hs_capable(hs), .line_attached, .reset_found_hs);
	upce_port_status u_dut (.core_clk, .resetn, .port_power, .line_attached, .line_fault,
		.line_overcurrent, .reset_found_hs, .sw_port_reset, .sw_wr, .sw_wdata, .tx_data_valid,
		.status_q, .port_enabled_flag, .connect_change_flag, .connect_present_flag,
		.enable_change_flag, .overcurrent_change_flag, .port_reset_active_q, .tx_data_pass_q);

	// Expected status word with no enable or over-current change pending
	function automatic upce_word_t word(logic p, logic c, logic e);
		return {3'h0, e, c, p};
	endfunction
	task automatic chk(string n, upce_word_t e, upce_word_t g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask
	// One-cycle software write, then time for the flags to settle
	task automatic wr(upce_word_t d);
		sw_wr = 1'b1;
		sw_wdata = d;
		cyc(1);
		sw_wr = 1'b0;
		cyc(4);
	endtask
	// Port reset with the device answering at the given speed
	task automatic preset(logic h);
		hs = h;
		sw_port_reset = 1'b1;
		cyc(1);
		sw_port_reset = 1'b0;
		cyc(3);
		chk("reset_active", 6'h01, 6'(port_reset_active_q));
		cyc(UPCE_PORT_RESET_CYC + 5);
		chk("enabled", 6'(h), 6'(port_enabled_flag));
	endtask
	task automatic close_out();
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		{resetn, port_power, line_fault, line_overcurrent, sw_port_reset} = 5'h00;
		{sw_wr, tx_data_valid, plug, hs} = 4'h0;
		sw_wdata = '0;
		failures = 0;
		comparisons = 0;
		cycles = 0;
		void'($urandom(71062));
		cyc(4);
		resetn = 1'b1;
		port_power = 1'b1;
		cyc(2);
		chk("after_reset", 6'h00, status_q);
		tx_data_valid = 1'b1;
		plug = 1'b1;
		wr(6'h04);
		chk("attach", word(1'b1, 1'b1, 1'b0), status_q);
		chk("pass_off", 6'h00, 6'(tx_data_pass_q));
		plug = 1'b0;
		cyc(5);
		plug = 1'b1;
		cyc(5);
		chk("sticky", word(1'b1, 1'b1, 1'b0), status_q);
		wr(6'h00);
		chk("zero_write", word(1'b1, 1'b1, 1'b0), status_q);
		wr(6'h02);
		chk("clear", word(1'b1, 1'b0, 1'b0), status_q);
		preset(1'b0);
		preset(1'b1);
		chk("pass_on", 6'h01, 6'(tx_data_pass_q));
		wr(6'h00);
		chk("sw_off", word(1'b1, 1'b0, 1'b0), status_q);
		preset(1'b1);
		line_fault = 1'b1;
		cyc(1);
		line_fault = 1'b0;
		cyc(4);
		chk("fault", 6'h09, status_q);
		chk("enchg_port", 6'h01, 6'(enable_change_flag));
		wr(6'h08);
		chk("enchg_clear", word(1'b1, 1'b0, 1'b0), status_q);
		chk("enchg_port_clear", 6'h00, 6'(enable_change_flag));
		line_overcurrent = 1'b1;
		cyc(4);
		chk("overcurrent_change_flag", 6'h01, 6'(overcurrent_change_flag));
		chk("oc_word", 6'h31, status_q);
		line_overcurrent = 1'b0;
		cyc(4);
		wr(6'h20);
		chk("overcurrent_change_flag_clear", 6'h00, 6'(overcurrent_change_flag));
		chk("oc_idle", 6'h01, status_q);
		// Random plugging with random data offers
		repeat (20) begin
			plug = 1'($urandom);
			tx_data_valid = 1'($urandom);
			cyc(4 + $urandom % 6);
			chk("present", 6'(plug), 6'(connect_present_flag));
		end
		port_power = 1'b0;
		cyc(3);
		chk("power_off", 6'h00, 6'(status_q[2:0]));
		close_out();
	end
endmodule

bind upce_port_status upce_port_status_asserts u_chk (.core_clk, .resetn, .port_power,
	.line_attached, .line_fault, .reset_found_hs, .sw_port_reset, .sw_wr, .sw_wdata,
	.tx_data_valid, .port_enabled_flag, .connect_change_flag, .connect_present_flag,
	.port_reset_active_q, .tx_data_pass_q);
